/* core/pmcc_top.sv */
// Performance monitor global control, counters, snapshot and identification registers behind APB
//
// The APB slave port and the address map were decided locally.
`include "pmcc_params.svh"
`default_nettype none
// How it works
// - Writing one to snapshot bit 0 copies all counters into shadow registers.
// - Without snapshot support the trigger bit reads zero and writes do nothing.
// - Config register bit 22 reads one: snapshot supported.
// - Config bits 13:8 read 31: counters are 32 bits wide.
// - Config bits 5:0 read 4: five counters; other bits read zero.
// - Global enable zero stops all counting; one permits counting.
// - Global enable overrides every per-counter enable.
// - Identification word bits 7:4 hold the architecture revision, read only.
// - Identification bit 3 reads one: standard manufacturer code used.
// - Identification bits 2:0 hold manufacturer code bits 6:4.
// - Counters and overflow records use a dedicated active-low monitor reset.
// - Counter n counts only with its own enable and global enable set.
// - Overflow interrupt enable acts only with global enable set.
// - Overflow sets the counter's flag and raises the monitor interrupt if enabled.
module pmcc_top
  import pmcc_pkg::*;
#(
  parameter bit SNAP_SUPPORTED = 1'b1
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic mon_rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [4:0] event_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  output logic pmu_irq_o,
  output logic ovf_irq_o,
  output logic [4:0] ovf_flags_o
);
  pmcc_apb_req_s req;
  logic ctrl_en_q, ctrl_en_d;
  logic [4:0] cnt_en_q, cnt_en_d, irqen_q, irqen_d, ovf_q, ovf_d;
  logic [159:0] cnt_q, cnt_d;
  logic [1:0] istat_q, istat_d, imask_q, imask_d;
  logic snap_q, snap_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d, oirq_q, oirq_d;
  logic [31:0] prdata_q, prdata_d;
  pmcc_apb_e st_q, st_d;
  logic [31:0] shadow_rd;
  logic [4:0] ovf_evt;
  logic wr_acc, rd_acc;
  logic [31:0] wmask;
  logic shd_rd;

  assign req = '{sel: psel_i, en: penable_i, wr: pwrite_i, addr: paddr_i, wdata: pwdata_i};

  // Decode whether an address falls in a counter or shadow window
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base);
    in_win = (a >= base) && (a < base + 12'h014) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] win_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    win_idx = off[4:2];
  endfunction

  // Access taken in the cycle pready is high
  assign wr_acc = ce_i && req.sel && req.en && pready_q && req.wr;
  assign rd_acc = ce_i && req.sel && req.en && pready_q && !req.wr;
  assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  // Shadow reads must wait for the bank's registered read port
  assign shd_rd = !req.wr && in_win(req.addr, `PMCC_OFF_SHADOW0);

  // APB slave: answers in the access cycle, shadow reads one cycle later
  always_comb begin
    st_d = st_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    case (st_q)
      PMCC_IDLE: begin
        if (req.sel && !req.en) begin
          st_d = PMCC_ACC;
          pready_d = !shd_rd; // Shadow data is not out of the bank yet
          prdata_d = 32'h00000000;
          case (req.addr)
            `PMCC_OFF_CTRL: prdata_d = {31'h0, ctrl_en_q};
            `PMCC_OFF_CNT_EN: prdata_d = {27'h0, cnt_en_q};
            `PMCC_OFF_IRQEN: prdata_d = {27'h0, irqen_q};
            `PMCC_OFF_OVF: prdata_d = {27'h0, ovf_q};
            `PMCC_OFF_SNAP: prdata_d = 32'h00000000;
            `PMCC_OFF_CFG: begin
              prdata_d[`PMCC_CFG_SNAP_BIT] = SNAP_SUPPORTED;
              prdata_d[13:8] = `PMCC_CFG_SIZE_VAL;
              prdata_d[5:0] = `PMCC_CFG_CNT_MINUS1_VAL;
            end
            `PMCC_OFF_PID2: begin
              prdata_d[7:4] = `PMCC_PID_ARCH_VAL;
              prdata_d[3] = `PMCC_PID_STD_ID;
              prdata_d[2:0] = `PMCC_PID_MFR_HI;
            end
            `PMCC_OFF_ISTAT: prdata_d = {30'h0, istat_q};
            `PMCC_OFF_IMASK: prdata_d = {30'h0, imask_q};
            default: begin
              if (in_win(req.addr, `PMCC_OFF_EVCNT0)) begin
                prdata_d = cnt_q[win_idx(req.addr, `PMCC_OFF_EVCNT0)*32 +: 32];
              end else if (!in_win(req.addr, `PMCC_OFF_SHADOW0)) begin
                pslverr_d = 1'b1;
              end
            end
          endcase
        end
      end
      PMCC_ACC: begin
        if (!pready_q) begin
          // Shadow read: bank output is valid now, answer next cycle
          pready_d = 1'b1;
          prdata_d = shadow_rd;
        end else begin
          st_d = PMCC_IDLE;
        end
      end
      default: st_d = PMCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q <= PMCC_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (ce_i) begin
      st_q <= st_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Control, enables, and interrupt status/mask on the domain reset
  always_comb begin
    ctrl_en_d = ctrl_en_q;
    cnt_en_d = cnt_en_q;
    irqen_d = irqen_q;
    imask_d = imask_q;
    istat_d = istat_q;
    snap_d = 1'b0;
    if (wr_acc && pstrb_i[0]) begin
      case (req.addr)
        `PMCC_OFF_CTRL: ctrl_en_d = req.wdata[0];
        `PMCC_OFF_CNT_EN: cnt_en_d = req.wdata[4:0];
        `PMCC_OFF_IRQEN: irqen_d = req.wdata[4:0];
        `PMCC_OFF_IMASK: imask_d = req.wdata[1:0];
        `PMCC_OFF_ISTAT: istat_d = istat_q & ~req.wdata[1:0];
        `PMCC_OFF_SNAP: snap_d = SNAP_SUPPORTED & req.wdata[0];
        default: ;
      endcase
    end
    // Set wins over clear: bit0 overflow event, bit1 snapshot done
    istat_d = istat_d | {snap_q, |ovf_evt};
    irq_d = |(istat_d & imask_d);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_en_q <= 1'b0;
      cnt_en_q <= 5'h00;
      irqen_q <= 5'h00;
      imask_q <= 2'h0;
      istat_q <= 2'h0;
      snap_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      ctrl_en_q <= ctrl_en_d;
      cnt_en_q <= cnt_en_d;
      irqen_q <= irqen_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      snap_q <= snap_d;
      irq_q <= irq_d;
    end
  end

  // Counters and overflow flags, one slice per counter
  genvar gi;
  generate
    for (gi = 0; gi < `PMCC_NUM_CNT; gi++) begin : g_cnt
      logic inc;
      assign inc = ctrl_en_q && cnt_en_q[gi] && event_i[gi];
      assign ovf_evt[gi] = inc && (cnt_q[gi*32 +: 32] == 32'hFFFFFFFF);
      always_comb begin
        cnt_d[gi*32 +: 32] = cnt_q[gi*32 +: 32];
        ovf_d[gi] = ovf_q[gi];
        if (wr_acc && in_win(req.addr, `PMCC_OFF_EVCNT0) && win_idx(req.addr, `PMCC_OFF_EVCNT0) == 3'(gi)) begin
          cnt_d[gi*32 +: 32] = (cnt_q[gi*32 +: 32] & ~wmask) | (req.wdata & wmask);
        end
        if (inc) begin
          cnt_d[gi*32 +: 32] = cnt_q[gi*32 +: 32] + 32'h00000001;
        end
        if (wr_acc && pstrb_i[0] && req.addr == `PMCC_OFF_OVF && req.wdata[gi]) begin
          ovf_d[gi] = 1'b0;
        end
        if (ovf_evt[gi]) begin
          ovf_d[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Overflow interrupt gated by per-counter and global enable
  assign oirq_d = ctrl_en_q && |(ovf_q & irqen_q);

  always_ff @(posedge clk_sys_i) begin
    if (!mon_rst_n_i) begin
      cnt_q <= {5{`PMCC_CNT_RST}};
      ovf_q <= 5'h00;
      oirq_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      oirq_q <= oirq_d;
    end
  end

  pmcc_shadow_mem u_shadow (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(mon_rst_n_i),
    .ce_i(ce_i),
    .cap_i(snap_q),
    .cnt_i(cnt_q),
    .raddr_i(win_idx(req.addr, `PMCC_OFF_SHADOW0)),
    .rdata_o(shadow_rd)
  );

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;
  assign pmu_irq_o = irq_q;
  assign ovf_irq_o = oirq_q;
  assign ovf_flags_o = ovf_q;

  // Snapshot pulse lasts one cycle and only follows a write of one
  a_snap_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && snap_q |=> !snap_q) else $error("snapshot pulse longer than one cycle");
  a_snap_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && snap_q |-> $past(wr_acc) && SNAP_SUPPORTED) else $error("snapshot without write");
  a_snap_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !SNAP_SUPPORTED |-> !snap_q) else $error("snapshot taken without support");
  a_gen_stop: assert property (@(posedge clk_sys_i) disable iff (!mon_rst_n_i)
    ce_i && $past(ce_i) && !$past(ctrl_en_q) && !$past(wr_acc) |-> $stable(cnt_q))
    else $error("counter moved with global enable off");
  a_ovf_set: assert property (@(posedge clk_sys_i) disable iff (!mon_rst_n_i)
    ce_i && |ovf_evt |=> |ovf_q) else $error("overflow flag not set");
  a_oirq_gate: assert property (@(posedge clk_sys_i) disable iff (!mon_rst_n_i)
    ovf_irq_o |-> $past(ctrl_en_q)) else $error("overflow irq without global enable");
  // Clock enable low holds every counter and overflow flag
  a_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (!mon_rst_n_i)
    !ce_i && mon_rst_n_i |=> $stable(cnt_q) && $stable(ovf_q)) else $error("counter moved with clock enable low");

  // One APB setup cycle seen by an idle slave
  sequence s_setup;
    ce_i && psel_i && !penable_i && st_q == PMCC_IDLE;
  endsequence

  // Register answers come in the next cycle, shadow answers one cycle later
  a_apb_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_setup ##0 !shd_rd |=> pready_o) else $error("no ready after setup");
  a_shadow_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_setup ##0 shd_rd |=> !pready_o ##1 pready_o) else $error("shadow read answer not one cycle late");
  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i |=> pmu_irq_o == ((istat_q & imask_q) != 2'h0)) else $error("irq level differs from unmasked status");
  a_cnt_step: assert property (@(posedge clk_sys_i) disable iff (!mon_rst_n_i)
    ce_i && g_cnt[0].inc |=> cnt_q[31:0] == $past(cnt_q[31:0]) + 32'h00000001)
    else $error("counter did not step by one");

  // Fixed read-only words answer with their constant values
  a_cfg_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_setup ##0 (paddr_i == `PMCC_OFF_CFG) |=> prdata_o == {9'h000, SNAP_SUPPORTED, 8'h00,
    `PMCC_CFG_SIZE_VAL, 2'h0, `PMCC_CFG_CNT_MINUS1_VAL}) else $error("config word wrong");
  a_id_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_setup ##0 (paddr_i == `PMCC_OFF_PID2) |=> prdata_o == {24'h000000, `PMCC_PID_ARCH_VAL,
    `PMCC_PID_STD_ID, `PMCC_PID_MFR_HI}) else $error("identification word wrong");
endmodule // pmcc_top
`default_nettype wire

/* core/pmcc_params.svh */
// Register offsets, field positions, reset values and fixed read values of the monitor control block
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH
`define PMCC_OFF_CTRL 12'h000
`define PMCC_OFF_CNT_EN 12'h004
`define PMCC_OFF_IRQEN 12'h008
`define PMCC_OFF_OVF 12'h00C
`define PMCC_OFF_SNAP 12'h010
`define PMCC_OFF_CFG 12'h014
`define PMCC_OFF_PID2 12'h018
`define PMCC_OFF_EVCNT0 12'h020
`define PMCC_OFF_SHADOW0 12'h040
`define PMCC_OFF_ISTAT 12'h060
`define PMCC_OFF_IMASK 12'h064
`define PMCC_NUM_CNT 5
`define PMCC_CFG_SNAP_BIT 22
`define PMCC_CFG_SIZE_VAL 6'h1F
`define PMCC_CFG_CNT_MINUS1_VAL 6'h04
// Architecture revision value is arbitrary
`define PMCC_PID_ARCH_VAL 4'h1
`define PMCC_PID_STD_ID 1'b1
// Upper manufacturer code bits are arbitrary
`define PMCC_PID_MFR_HI 3'h5
`define PMCC_CNT_RST 32'h00000000
`endif

/* core/pmcc_pkg.sv */
// Types shared by the monitor control block
`default_nettype none
package pmcc_pkg;
  typedef logic [31:0] pmcc_word_t;
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    pmcc_word_t wdata;
  } pmcc_apb_req_s;
  typedef enum logic [1:0] {
    PMCC_IDLE = 2'b00,
    PMCC_ACC = 2'b01
  } pmcc_apb_e;
endpackage
`default_nettype wire

/* core/pmcc_shadow_mem.sv */
// Shadow register bank holding snapshot copies of the event counters
`default_nettype none
module pmcc_shadow_mem
  import pmcc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cap_i,
  input wire logic [159:0] cnt_i,
  input wire logic [2:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [159:0] mem_q;
  logic [159:0] mem_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Load every word at once on capture, read one word into a register
  always_comb begin
    mem_d = cap_i ? cnt_i : mem_q;
    rdata_d = (raddr_i < 3'd5) ? mem_q[raddr_i*32 +: 32] : 32'h00000000;
  end

  // Registers on the monitor reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mem_q <= 160'h0;
      rdata_q <= 32'h00000000;
    end else if (ce_i) begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule // pmcc_shadow_mem
`default_nettype wire

/* tb/pmcc_tb.sv */
// Self-checking APB testbench for the monitor control block
`include "pmcc_params.svh"
`default_nettype none
module tb import pmcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mon_rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  pmcc_word_t pwdata_i = 32'h00000000;
  logic [4:0] event_i = 5'h00;
  logic pready_o, pslverr_o, pmu_irq_o, ovf_irq_o;
  logic [31:0] prdata_o;
  logic [4:0] ovf_flags_o;
  logic [31:0] prdata_n;
  pmcc_word_t rd2_q;
  logic last_err;
  pmcc_word_t rd_q;
  int n_fail = 0;
  int checks_done = 0;

  // Clock at 125 MHz
  always #4 clk_sys_i = ~clk_sys_i;

  pmcc_top #(.SNAP_SUPPORTED(1'b1)) u_pmcc_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .mon_rst_n_i(mon_rst_n_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .event_i(event_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .pmu_irq_o(pmu_irq_o), .ovf_irq_o(ovf_irq_o),
    .ovf_flags_o(ovf_flags_o));

  // Second copy without snapshot support, fed the same stimulus
  pmcc_top #(.SNAP_SUPPORTED(1'b0)) u_pmcc_top_nosnap (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .mon_rst_n_i(mon_rst_n_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .event_i(event_i), .pready_o(),
    .pslverr_o(), .prdata_o(prdata_n), .pmu_irq_o(), .ovf_irq_o(), .ovf_flags_o());

  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input pmcc_word_t wdata);
    int i;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wdata;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      complete_run();
    end
    rd_q = prdata_o;
    rd2_q = prdata_n;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input pmcc_word_t d);
    apb(1'b1, addr, d);
  endtask

  task automatic rdc(input logic [11:0] addr, input pmcc_word_t exp, input string name);
    apb(1'b0, addr, 32'h00000000);
    chk(name, rd_q, exp);
  endtask

  // Presents an event mask for exactly n sampling edges
  task automatic ev(input logic [4:0] m, input int n);
    @(posedge clk_sys_i);
    event_i <= m;
    repeat (n) @(posedge clk_sys_i);
    event_i <= 5'h00;
  endtask

  task automatic tdone(input string name);
    $display("Test %s finished", name);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    mon_rst_n_i <= 1'b1;
    // Fixed identification and configuration words
    rdc(`PMCC_OFF_CFG, {9'h000, 1'b1, 8'h00, 6'h1F, 2'h0, 6'h04}, "config");
    chk("config nosnap", rd2_q, 32'h00001F04);
    rdc(`PMCC_OFF_PID2, {24'h000000, `PMCC_PID_ARCH_VAL, 1'b1, `PMCC_PID_MFR_HI}, "id2");
    wr(`PMCC_OFF_PID2, 32'hFFFFFFFF);
    rdc(`PMCC_OFF_PID2, {24'h000000, `PMCC_PID_ARCH_VAL, 1'b1, `PMCC_PID_MFR_HI}, "id2 ro");
    wr(`PMCC_OFF_CFG, 32'h00000000);
    rdc(`PMCC_OFF_CFG, 32'h00401F04, "config ro");
    rdc(12'h0FC, 32'h00000000, "unmapped");
    chk("pslverr", {31'h0, last_err}, 32'h00000001);
    tdone("ident");
    // Global enable off: nothing counts even with every counter enabled
    wr(`PMCC_OFF_CNT_EN, 32'h0000001F);
    ev(5'h1F, 6);
    for (int n = 0; n < 5; n++) rdc(12'h020 + 12'(4 * n), 32'h00000000, "cnt off");
    tdone("global off");
    // Global enable on: only individually enabled counters move
    wr(`PMCC_OFF_CTRL, 32'h00000001);
    wr(`PMCC_OFF_CNT_EN, 32'h00000005);
    ev(5'h1F, 7);
    for (int n = 0; n < 5; n++) rdc(12'h020 + 12'(4 * n), (n == 0 || n == 2) ? 32'h7 : 32'h0, "cnt on");
    tdone("counting");
    // Snapshot copies every counter once; trigger never reads back set
    wr(`PMCC_OFF_SNAP, 32'h00000001);
    rdc(`PMCC_OFF_SNAP, 32'h00000000, "snap bit");
    chk("snap bit nosnap", rd2_q, 32'h00000000);
    ev(5'h01, 3);
    for (int n = 0; n < 5; n++) begin
      rdc(12'h040 + 12'(4 * n), (n == 0 || n == 2) ? 32'h7 : 32'h0, "shadow");
      chk("shadow nosnap", rd2_q, 32'h00000000);
    end
    rdc(`PMCC_OFF_EVCNT0, 32'h0000000A, "cnt0 after");
    tdone("snapshot");
    // Overflow of counter 0 sets its flag and the interrupts
    wr(`PMCC_OFF_EVCNT0, 32'hFFFFFFFF);
    wr(`PMCC_OFF_IRQEN, 32'h00000001);
    ev(5'h01, 1);
    repeat (3) @(posedge clk_sys_i);
    chk("ovf flags", {27'h0, ovf_flags_o}, 32'h00000001);
    chk("ovf irq", {31'h0, ovf_irq_o}, 32'h00000001);
    rdc(`PMCC_OFF_EVCNT0, 32'h00000000, "wrap");
    wr(`PMCC_OFF_CTRL, 32'h00000000);
    repeat (3) @(posedge clk_sys_i);
    chk("ovf irq off", {31'h0, ovf_irq_o}, 32'h00000000);
    wr(`PMCC_OFF_CTRL, 32'h00000001);
    rdc(`PMCC_OFF_ISTAT, 32'h00000003, "istat");
    chk("istat nosnap", rd2_q, 32'h00000001);
    chk("irq masked", {31'h0, pmu_irq_o}, 32'h00000000);
    wr(`PMCC_OFF_IMASK, 32'h00000001);
    repeat (2) @(posedge clk_sys_i);
    chk("irq on", {31'h0, pmu_irq_o}, 32'h00000001);
    wr(`PMCC_OFF_ISTAT, 32'h00000003);
    repeat (2) @(posedge clk_sys_i);
    chk("irq clr", {31'h0, pmu_irq_o}, 32'h00000000);
    wr(`PMCC_OFF_OVF, 32'h00000001);
    repeat (2) @(posedge clk_sys_i);
    chk("ovf clr", {27'h0, ovf_flags_o}, 32'h00000000);
    tdone("overflow");
    // Monitor reset clears counters and shadows but not global control
    wr(`PMCC_OFF_OVF, 32'h00000000);
    @(posedge clk_sys_i);
    mon_rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    mon_rst_n_i <= 1'b1;
    rdc(`PMCC_OFF_CTRL, 32'h00000001, "ctrl kept");
    rdc(12'h028, 32'h00000000, "cnt2 rst");
    rdc(12'h048, 32'h00000000, "shadow2 rst");
    tdone("monitor reset");
    // Clock enable low freezes the counters; counting resumes after
    ce_i <= 1'b0;
    ev(5'h05, 4);
    ce_i <= 1'b1;
    rdc(`PMCC_OFF_EVCNT0, 32'h00000000, "cnt frozen");
    ev(5'h05, 2);
    rdc(`PMCC_OFF_EVCNT0, 32'h00000002, "cnt resumed");
    tdone("clock enable");
    complete_run();
  end
endmodule // tb
`default_nettype wire
